// ==== mqa_pkg.sv ====
// Constants for the modem, queue and fault action configuration bank.
// Operation
// - Resolution bit clear gives 32 steps per period at 38.4 kHz.
// - Resolution bit set gives 128 steps per period at 153.6 kHz.
// - Amplitude code adds 25 mVpp per step from 400, saturates at 800.
// - Modem enable turns transmitter and receiver on; both off when clear.
// - Loopback routes the transmit signal into the receive path.
// - Idle transmit output parks at midcode, or floats when selected.
// - Request-to-send starts modulation only while carrier detect is low.
// - Writing one flushes the receive queue pointers; bit self-clears.
// - Writing one flushes the transmit queue pointers; bit self-clears.
// - Receive level flag trips when fill exceeds trip setting times two.
// - Transmit level flag trips when fill is below trip setting times two.
// - Action codes: none, clear state, alarm voltage, high impedance.
// - Bits 15-14 act on self-diagnostic faults; reset to alarm voltage.
// - Bits 13-12 act on die temperature out of limits.
// - Bits 11-10 act on second auxiliary input out of limits.
// - Bits 9-8 act on first auxiliary input out of limits.
// - Bits 7-6 act on link frame check or watchdog errors.
// - Bits 5-4 act on reference faults; reset to alarm voltage.
// - Bits 3-2 act on the overheat error indication.
// - Bits 1-0 act on the overheat warning indication.
// - Alarm level high when polarity bit set or free polarity pin high.
package mqa_pkg;
  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_MODEM = 7'h0E;
  localparam logic [6:0] ADDR_QUEUE = 7'h0F;
  localparam logic [6:0] ADDR_FAULT = 7'h10;
  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODEM_RST = 16'h0040;
  localparam logic [15:0] QUEUE_RST = 16'h00F0;
  localparam logic [15:0] FAULT_RST = 16'h8020;
  localparam logic [15:0] MODEM_WMASK = 16'h03FF;
  localparam logic [15:0] QUEUE_WMASK = 16'h00FF;
  localparam int RES_BIT = 9;
  localparam int AMP_LSB = 4;
  localparam int EN_BIT = 3;
  localparam int LOOP_BIT = 2;
  localparam int FLOAT_BIT = 1;
  localparam int RTS_BIT = 0;
  localparam int RXFL_BIT = 9;
  localparam int TXFL_BIT = 8;
  localparam int RXLV_LSB = 4;
  localparam int TXLV_LSB = 0;
  localparam int NUM_FAULTS = 8;
  // ----------------------------------------------------------------------
  // Waveform timing
  // ----------------------------------------------------------------------
  localparam logic [6:0] STEPS_LO = 7'h1F;
  localparam logic [6:0] STEPS_HI = 7'h7F;
  localparam int CLK_HZ = 20000000;
  localparam int UPD_LO_HZ = 38400;
  localparam int UPD_HI_HZ = 153600;
  localparam int DIV_LO = CLK_HZ / UPD_LO_HZ;
  localparam int DIV_HI = CLK_HZ / UPD_HI_HZ;
  // ----------------------------------------------------------------------
  // Amplitude in mVpp
  // ----------------------------------------------------------------------
  localparam logic [9:0] AMP_BASE_MV = 10'h190;
  localparam logic [9:0] AMP_STEP_MV = 10'h019;
  localparam logic [9:0] AMP_MAX_MV = 10'h320;
  // ----------------------------------------------------------------------
  // Fault actions
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_CLEAR = 2'h1,
    ACT_ALARM = 2'h2,
    ACT_HIZ = 2'h3
  } mqa_act_t;
endpackage

// ==== mqa_fault_map.sv ====
// Maps fault sources through their action fields to one worst action.
`timescale 1ns/1ns
module mqa_fault_map (
  input wire logic [15:0] action_fields,
  input wire logic [7:0] fault_active,
  output mqa_pkg::mqa_act_t worst_action
);
  function automatic logic [1:0] pick(input logic [1:0] a,
                                      input logic [1:0] b);
    pick = (a > b) ? a : b;
  endfunction

  logic [1:0] acc [0:8];
  assign acc[0] = 2'h0;
  genvar i;
  generate
    for (i = 0; i < mqa_pkg::NUM_FAULTS; i++) begin : g_src
      // Field i covers bits 2i+1:2i; index 7 is bits 15-14.
      assign acc[i+1] = pick(acc[i],
        fault_active[i] ? action_fields[2*i+1:2*i] : 2'h0);
    end
  endgenerate
  assign worst_action = mqa_pkg::mqa_act_t'(acc[8]);
endmodule

// ==== mqa_config.sv ====
// Register bank for modem, queue and fault action configuration.
`timescale 1ns/1ns
module mqa_config (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic carrier_detect_flag,
  input wire logic polarity_or_aux_pin,
  input wire logic alarm_level_polarity,
  input wire logic aux_pin_adc_select,
  input wire logic [4:0] rx_queue_fill,
  input wire logic [4:0] tx_queue_fill,
  input wire logic selfcheck_fault,
  input wire logic die_temp_fault,
  input wire logic aux_input1_fault,
  input wire logic aux_input0_fault,
  input wire logic link_check_fault,
  input wire logic reference_fault,
  input wire logic overheat_error,
  input wire logic overheat_warning,
  output logic modem_enable,
  output logic tx_enable,
  output logic rx_enable,
  output logic loopback_enable,
  output logic tx_output_park_midcode,
  output logic tx_output_float,
  output logic modulator_active,
  output logic [6:0] tx_step_index,
  output logic tx_step_strobe,
  output logic [9:0] tx_amplitude_mv,
  output logic rx_queue_flush,
  output logic tx_queue_flush,
  output logic rx_queue_level_flag,
  output logic tx_queue_level_flag,
  output mqa_pkg::mqa_act_t fault_action,
  output logic alarm_level_high
);
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [15:0] modem_q;
  logic [15:0] queue_q;
  logic [15:0] fault_q;
  logic rx_flush_q;
  logic tx_flush_q;
  logic wr_modem;
  logic wr_queue;
  logic wr_fault;
  assign wr_modem = reg_wr && (reg_addr == mqa_pkg::ADDR_MODEM);
  assign wr_queue = reg_wr && (reg_addr == mqa_pkg::ADDR_QUEUE);
  assign wr_fault = reg_wr && (reg_addr == mqa_pkg::ADDR_FAULT);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modem_q <= mqa_pkg::MODEM_RST;
      queue_q <= mqa_pkg::QUEUE_RST;
      fault_q <= mqa_pkg::FAULT_RST;
    end else begin
      if (wr_modem) begin
        modem_q <= reg_wdata & mqa_pkg::MODEM_WMASK;
      end
      if (wr_queue) begin
        queue_q <= reg_wdata & mqa_pkg::QUEUE_WMASK;
      end
      if (wr_fault) begin
        fault_q <= reg_wdata;
      end
    end
  end

  // Flush bits live one cycle; a read never shows them set.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end else begin
      rx_flush_q <= wr_queue && reg_wdata[mqa_pkg::RXFL_BIT];
      tx_flush_q <= wr_queue && reg_wdata[mqa_pkg::TXFL_BIT];
    end
  end
  assign rx_queue_flush = rx_flush_q;
  assign tx_queue_flush = tx_flush_q;

  logic [15:0] rd_mux;
  assign rd_mux = (reg_addr == mqa_pkg::ADDR_MODEM) ? modem_q :
                  (reg_addr == mqa_pkg::ADDR_QUEUE) ? queue_q :
                  (reg_addr == mqa_pkg::ADDR_FAULT) ? fault_q : 16'h0000;
  assign reg_rdata = rd_mux;

  // ----------------------------------------------------------------------
  // Modem control
  // ----------------------------------------------------------------------
  logic en;
  logic res_hi;
  logic [4:0] amp_code;
  assign en = modem_q[mqa_pkg::EN_BIT];
  assign res_hi = modem_q[mqa_pkg::RES_BIT];
  assign amp_code = modem_q[mqa_pkg::AMP_LSB+4:mqa_pkg::AMP_LSB];
  assign modem_enable = en;
  assign tx_enable = en;
  assign rx_enable = en;
  assign loopback_enable = en && modem_q[mqa_pkg::LOOP_BIT];

  logic mod_d;
  logic mod_q;
  assign mod_d = en && modem_q[mqa_pkg::RTS_BIT] && !carrier_detect_flag;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_q <= 1'b0;
    end else begin
      mod_q <= mod_d;
    end
  end
  assign modulator_active = mod_q;
  assign tx_output_park_midcode = !mod_q && !modem_q[mqa_pkg::FLOAT_BIT];
  assign tx_output_float = !mod_q && modem_q[mqa_pkg::FLOAT_BIT];

  // Amplitude saturates: the top code bit alone selects the ceiling.
  assign tx_amplitude_mv = amp_code[4] ? mqa_pkg::AMP_MAX_MV :
    10'(mqa_pkg::AMP_BASE_MV + 10'(amp_code[3:0]) * mqa_pkg::AMP_STEP_MV);

  // ----------------------------------------------------------------------
  // Waveform step pacing
  // ----------------------------------------------------------------------
  logic [9:0] div_q;
  logic [9:0] div_top;
  logic [6:0] step_q;
  logic [6:0] step_top;
  logic tick;
  assign div_top = res_hi ? 10'(mqa_pkg::DIV_HI - 1) :
                            10'(mqa_pkg::DIV_LO - 1);
  assign step_top = res_hi ? mqa_pkg::STEPS_HI : mqa_pkg::STEPS_LO;
  assign tick = mod_q && (div_q >= div_top);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 10'h000;
      step_q <= 7'h00;
    end else if (!mod_q) begin
      div_q <= 10'h000;
      step_q <= 7'h00;
    end else if (tick) begin
      div_q <= 10'h000;
      step_q <= (step_q >= step_top) ? 7'h00 : 7'(step_q + 7'h01);
    end else begin
      div_q <= 10'(div_q + 10'h001);
    end
  end
  assign tx_step_index = step_q;
  assign tx_step_strobe = tick;

  // ----------------------------------------------------------------------
  // Queue level flags
  // ----------------------------------------------------------------------
  logic [4:0] rx_trip;
  logic [4:0] tx_trip;
  assign rx_trip = {queue_q[mqa_pkg::RXLV_LSB+3:mqa_pkg::RXLV_LSB], 1'b0};
  assign tx_trip = {queue_q[mqa_pkg::TXLV_LSB+3:mqa_pkg::TXLV_LSB], 1'b0};
  assign rx_queue_level_flag = rx_queue_fill > rx_trip;
  assign tx_queue_level_flag = tx_queue_fill < tx_trip;

  // ----------------------------------------------------------------------
  // Fault to action mapping
  // ----------------------------------------------------------------------
  logic [7:0] faults;
  assign faults = {selfcheck_fault, die_temp_fault, aux_input1_fault,
                   aux_input0_fault, link_check_fault, reference_fault,
                   overheat_error, overheat_warning};
  mqa_fault_map u_map (
    .action_fields(fault_q),
    .fault_active(faults),
    .worst_action(fault_action)
  );

  // The pin is asynchronous to clk, so two flops retime it before use.
  logic pol_pin_meta_q;
  logic pol_pin_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pol_pin_meta_q <= 1'b0;
      pol_pin_q <= 1'b0;
    end else begin
      pol_pin_meta_q <= polarity_or_aux_pin;
      pol_pin_q <= pol_pin_meta_q;
    end
  end

  // The pin only counts as polarity while the converter does not own it.
  assign alarm_level_high = alarm_level_polarity ||
    (pol_pin_q && !aux_pin_adc_select);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Back to back flush writes are legal, so each pulse tracks its write.
  flush_rx_a: assert property (@(posedge clk) disable iff (sys_rst)
    rx_queue_flush == $past(wr_queue && reg_wdata[mqa_pkg::RXFL_BIT]))
    else $error("rx flush pulse wrong");
  flush_tx_a: assert property (@(posedge clk) disable iff (sys_rst)
    tx_queue_flush == $past(wr_queue && reg_wdata[mqa_pkg::TXFL_BIT]))
    else $error("tx flush pulse wrong");
  rts_cd_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(carrier_detect_flag) |-> !modulator_active)
    else $error("modulating with carrier present");
  enable_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !modem_enable |-> (!tx_enable && !rx_enable && !modulator_active) ||
    $past(modem_enable))
    else $error("modem active while disabled");
  idle_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    !modulator_active |-> (tx_output_float ^ tx_output_park_midcode))
    else $error("idle output state wrong");
  amp_sat_a: assert property (@(posedge clk) disable iff (sys_rst)
    amp_code[4] |-> tx_amplitude_mv == mqa_pkg::AMP_MAX_MV)
    else $error("amplitude not saturated");
  rx_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    rx_queue_level_flag |-> rx_queue_fill >
    {queue_q[mqa_pkg::RXLV_LSB+3:mqa_pkg::RXLV_LSB], 1'b0})
    else $error("rx level flag wrong");
  tx_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    tx_queue_level_flag |-> tx_queue_fill <
    {queue_q[mqa_pkg::TXLV_LSB+3:mqa_pkg::TXLV_LSB], 1'b0})
    else $error("tx level flag wrong");
  sd_action_a: assert property (@(posedge clk) disable iff (sys_rst)
    selfcheck_fault |-> fault_action >= fault_q[15:14])
    else $error("self check action lost");
  alarm_pol_a: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_level_polarity |-> alarm_level_high)
    else $error("alarm polarity ignored");
endmodule

// ==== mqa_host.sv ====
// Host model that writes and reads the bank's registers.
`timescale 1ns/1ns
module mqa_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output logic reg_wr,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end
  // The strobe drops at the taking edge, so writes are never merged.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the modem, queue and fault action bank.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cd = 1'b0, pin = 1'b0, pol = 1'b0, adsel = 1'b0;
  logic [4:0] rxf = 5'h00, txf = 5'h00;
  logic [7:0] flt = 8'h00;
  logic reg_wr, m_en, tx_en, rx_en, lb, park, flo, mod_act, strobe;
  logic rx_fl, tx_fl, rx_lv, tx_lv, alarm_hi;
  logic [6:0] reg_addr, step;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [9:0] amp_mv;
  mqa_pkg::mqa_act_t act;
  int num_errors = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  mqa_host i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  mqa_config i_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .carrier_detect_flag(cd), .polarity_or_aux_pin(pin),
    .alarm_level_polarity(pol), .aux_pin_adc_select(adsel),
    .rx_queue_fill(rxf), .tx_queue_fill(txf), .selfcheck_fault(flt[7]),
    .die_temp_fault(flt[6]), .aux_input1_fault(flt[5]),
    .aux_input0_fault(flt[4]), .link_check_fault(flt[3]),
    .reference_fault(flt[2]), .overheat_error(flt[1]),
    .overheat_warning(flt[0]), .modem_enable(m_en), .tx_enable(tx_en),
    .rx_enable(rx_en), .loopback_enable(lb), .tx_output_park_midcode(park),
    .tx_output_float(flo), .modulator_active(mod_act),
    .tx_step_index(step), .tx_step_strobe(strobe), .tx_amplitude_mv(amp_mv),
    .rx_queue_flush(rx_fl), .tx_queue_flush(tx_fl),
    .rx_queue_level_flag(rx_lv), .tx_queue_level_flag(tx_lv),
    .fault_action(act), .alarm_level_high(alarm_hi));
  // ------------------------------------------------------------------
  // Shared checks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    i_host.rd(a, rd_val);
    chk("readback", e, rd_val);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rchk(mqa_pkg::ADDR_MODEM, 16'h0040);
    rchk(mqa_pkg::ADDR_QUEUE, 16'h00F0);
    rchk(mqa_pkg::ADDR_FAULT, 16'h8020);
    rchk(7'h11, 16'h0000);
    chk("amp", 16'h01F4, 16'(amp_mv));
    chk("enables", 16'h0000, {13'h0000, m_en, tx_en, rx_en});
    chk("idle out", 16'h0001, {14'h0000, flo, park});
    i_host.wr(7'h11, 16'hFFFF);
    i_host.wr(mqa_pkg::ADDR_MODEM, 16'hFFF0);
    rchk(mqa_pkg::ADDR_MODEM, 16'h03F0);
    rchk(mqa_pkg::ADDR_FAULT, 16'h8020);
  endtask
  task automatic t_amp;
    for (int c = 0; c < 32; c++) begin
      i_host.wr(mqa_pkg::ADDR_MODEM, 16'(c) << mqa_pkg::AMP_LSB);
      @(negedge clk);
      chk("amp", (c > 15) ? 16'h0320 : 16'h0190 + 16'h0019 * 16'(c),
          16'(amp_mv));
    end
  endtask
  task automatic t_modem;
    i_host.wr(mqa_pkg::ADDR_MODEM, 16'h000E);
    @(negedge clk);
    chk("en lb", 16'h000F, {12'h000, m_en, tx_en, rx_en, lb});
    chk("idle out", 16'h0002, {14'h0000, flo, park});
    i_host.wr(mqa_pkg::ADDR_MODEM, 16'h000B);
    repeat (2) @(negedge clk);
    chk("modulate", 16'h0001, 16'(mod_act));
    chk("busy out", 16'h0000, {14'h0000, flo, park});
    @(posedge clk);
    cd <= 1'b1;
    repeat (2) @(negedge clk);
    chk("carrier stop", 16'h0000, 16'(mod_act));
    @(posedge clk);
    cd <= 1'b0;
    i_host.wr(mqa_pkg::ADDR_MODEM, 16'h0000);
    repeat (2) @(negedge clk);
    chk("off", 16'h0001, {11'h000, mod_act, tx_en, rx_en, flo, park});
  endtask
  task automatic t_queue;
    // Trip settings are written here with the modem left off by t_modem.
    i_host.wr(mqa_pkg::ADDR_QUEUE, 16'h0353);
    @(negedge clk);
    chk("flush", 16'h0003, {14'h0000, rx_fl, tx_fl});
    @(negedge clk);
    chk("flush end", 16'h0000, {14'h0000, rx_fl, tx_fl});
    rchk(mqa_pkg::ADDR_QUEUE, 16'h0053);
    for (int f = 5; f < 12; f++) begin
      @(posedge clk);
      rxf <= 5'(f);
      txf <= 5'(f);
      @(negedge clk);
      chk("rx level", 16'(f > 10), 16'(rx_lv));
      chk("tx level", 16'(f < 6), 16'(tx_lv));
    end
  endtask
  task automatic t_src(input int i, input logic [1:0] code);
    i_host.wr(mqa_pkg::ADDR_FAULT, 16'(code) << (2 * i));
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      flt <= 8'h01 << j;
      @(negedge clk);
      chk("action", (i == j) ? 16'(code) : 16'h0000, 16'(act));
    end
  endtask
  task automatic t_fault;
    t_src(0, 2'h1);
    t_src(1, 2'h2);
    t_src(2, 2'h3);
    t_src(3, 2'h1);
    t_src(4, 2'h2);
    t_src(5, 2'h3);
    t_src(6, 2'h1);
    t_src(7, 2'h3);
    // Codes one, two and three meet in one word to rank them.
    i_host.wr(mqa_pkg::ADDR_FAULT, 16'h0039);
    for (int j = 1; j < 8; j++) begin
      @(posedge clk);
      flt <= 8'(j);
      @(negedge clk);
      chk("worst", 16'((j > 3) ? 3 : ((j > 1) ? 2 : 1)), 16'(act));
    end
    @(posedge clk);
    flt <= 8'h00;
  endtask
  task automatic t_pol;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {pol, pin, adsel} <= 3'(k);
      // The pin passes two retiming flops before it reaches the output.
      repeat (3) @(negedge clk);
      chk("alarm", 16'(k[2] | (k[1] & !k[0])), 16'(alarm_hi));
    end
  endtask
  task automatic t_steps(input logic res, input int div,
                         input logic [6:0] top);
    int n;
    logic [6:0] mx;
    mx = 7'h00;
    i_host.wr(mqa_pkg::ADDR_MODEM, {6'h00, res, 9'h009});
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (strobe !== 1'b1 && n < 2000);
    end
    chk("period", 16'(div), 16'(n));
    for (int k = 0; k < (int'(top) + 2) * div; k++) begin
      @(negedge clk);
      if (step > mx) mx = step;
    end
    chk("top step", 16'(top), 16'(mx));
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_amp;
    t_modem;
    t_queue;
    t_fault;
    t_pol;
    t_steps(1'b0, mqa_pkg::DIV_LO, mqa_pkg::STEPS_LO);
    t_steps(1'b1, mqa_pkg::DIV_HI, mqa_pkg::STEPS_HI);
    close_out;
  end
  // The step runs dominate; this span leaves ample margin beyond them.
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    close_out;
  end
endmodule
